// >>> hdl/osc_switch_pkg.sv
// Constants and types shared by the oscillator switch control block.
// Assumes a single 100 MHz register clock and a plain strobe register port.
package osc_switch_pkg;

   // Register word addresses on the plain port.
   localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_CLK_DIVIDER = 2'h1;
   localparam logic [1:0] ADDR_FRC_TUNE    = 2'h2;

   // Byte-write selects carried in bits 17:16 of the write data.
   localparam int BYTE_SEL_LO = 16;
   localparam int BYTE_SEL_HI = 17;

   // Unlock keys for the high and low control bytes.
   localparam logic [7:0] KEY_HI_1 = 8'h78;
   localparam logic [7:0] KEY_HI_2 = 8'h9A;
   localparam logic [7:0] KEY_LO_1 = 8'h46;
   localparam logic [7:0] KEY_LO_2 = 8'h57;

   // Field positions in oscillator_control.
   localparam int POS_CUR_SRC   = 12;
   localparam int POS_NEW_SRC   = 8;
   localparam int POS_SEL_LOCK  = 7;
   localparam int POS_IO_LOCK   = 6;
   localparam int POS_PLL_LOCK  = 5;
   localparam int POS_FAIL      = 3;
   localparam int POS_PRI_SLEEP = 2;
   localparam int POS_SEC_EN    = 1;
   localparam int POS_SWITCH    = 0;

   // Field positions in clock_divider.
   localparam int POS_ROI       = 15;
   localparam int POS_RATIO     = 12;
   localparam int POS_RATIO_EN  = 11;
   localparam int POS_POSTSCALE = 8;

   // Reset values.
   localparam logic [2:0] RST_POSTSCALE = 3'h1;
   localparam logic [2:0] RST_RATIO     = 3'h0;
   localparam logic [5:0] RST_TRIM      = 6'h00;

   // Clock source encodings.
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI      = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_SEC      = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h5;
   localparam logic [2:0] SRC_RSVD     = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV  = 3'h7;

   // New-clock cycles counted before the changeover.
   localparam logic [3:0] SETTLE_CYCLES = 4'hA;

   // Switch sequencer states, Gray coded from ST_IDLE to ST_SWAP; the return to ST_IDLE changes two bits.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_WAIT   = 3'b011,
      ST_SETTLE = 3'b010,
      ST_SWAP   = 3'b110
   } sw_state_e;

endpackage : osc_switch_pkg

// >>> hdl/osc_switch_ctrl.sv
// Oscillator selection, switch sequencer, doze ratio, postscaler and trim.
// Assumes oscillator ready flags and failure events arrive from
// other clock domains and are synchronised here.
//
// Functional notes
// - Selection lock refuses switching while monitor enabled.
// - PLL lock flag follows PLL, cleared on switch.
// - Clock fail flag set by monitor, software clears.
// - Primary sleep keep and secondary force on.
// - IO lock needs unlock; one-way keeps it set.
// - Recover on interrupt clears ratio enable.
// - Doze ratio 1:1 up to 1:128.
// - Fast RC postscaler power of two, reset divide 2.
// - Trim is signed six-bit offset.
// - Switching allowed only when config equals 00.
// - Disabled switching reports initial source config.
// - Disabled switching holds switch request at 0.
// - Primary submode fixed by configuration only.
// - Equal sources abort switch, clear request.
// - Valid switch start clears lock and fail.
// - Enable new oscillator, wait start-up and, for PLL targets, lock.
// - Count ten new-clock cycles before changeover.
// - Completion clears request, copies new source.
// - Stop old source with RC/secondary exceptions.
// - Source encoding of current and new fields.
`timescale 1ns/1ns
module osc_switch_ctrl
   import osc_switch_pkg::*;
(
   input  wire logic        ref_clk,           // System register clock.
   input  wire logic        rstn,              // Asynchronous reset, low.
   input  wire logic [1:0]  reg_addr,          // Register word address.
   input  wire logic [17:0] reg_wdata,         // Data plus byte selects.
   input  wire logic        reg_wr,            // Write strobe.
   input  wire logic        reg_rd,            // Read strobe.
   output logic      [15:0] reg_rdata,         // Read data, next cycle.
   input  wire logic [1:0]  switch_monitor_config, // Static config.
   input  wire logic [2:0]  initial_source_config, // Static config.
   input  wire logic [1:0]  primary_submode_config,// Static config.
   input  wire logic        one_way_io_lock,   // Static config.
   input  wire logic        watchdog_enable,   // Static config.
   input  wire logic        osc_ready_async,   // Start-up timer done.
   input  wire logic        pll_locked_async,  // PLL lock detector.
   input  wire logic        new_clk_tick_async,// New source clock.
   input  wire logic        clock_fail_async,  // Monitor failure level.
   input  wire logic        interrupt_event,   // Core interrupt, same clock.
   input  wire logic        sleep_mode,        // Core sleep, same clock.
   output logic      [2:0]  system_source,     // Source feeding the core.
   output logic      [7:0]  osc_enable,        // One enable per source code.
   output logic      [1:0]  primary_submode,   // Fixed primary submode.
   output logic      [2:0]  cpu_ratio_log2,    // Effective doze shift.
   output logic      [3:0]  fast_rc_div_log2,  // Postscaler shift.
   output logic signed [5:0] fast_rc_trim_out, // Signed trim offset.
   output logic             io_lock_out,       // Mapping lock level.
   output logic             pll_select         // Current source uses PLL.
);

   ////////////////////////////////////////////////////////////////////////
   // State record. One struct holds every flip-flop of the block.
   typedef struct packed {
      logic [2:0]  sync_rdy;       // Start-up ready synchroniser.
      logic [2:0]  sync_pll;       // PLL lock synchroniser.
      logic [2:0]  sync_tick;      // New-clock synchroniser.
      logic        tick_lvl;       // Last agreed new-clock level.
      logic [2:0]  sync_fail;      // Failure synchroniser.
      logic        boot_done;      // Straps captured after reset.
      logic [2:0]  cur_src;        // Current source field.
      logic [2:0]  new_src;        // New source selection.
      logic        sel_lock;       // Selection lock, set only.
      logic        io_lock;        // Mapping lock.
      logic        pll_lock;       // PLL lock flag.
      logic        fail;           // Clock fail flag.
      logic        pri_sleep;      // Primary kept in sleep.
      logic        sec_en;         // Secondary forced on.
      logic        sw_req;         // Switch request.
      logic [1:0]  hi_key;         // High byte unlock progress.
      logic [1:0]  lo_key;         // Low byte unlock progress.
      logic        recover_on_interrupt;            // Recover on interrupt.
      logic [2:0]  ratio;          // Doze ratio code.
      logic        ratio_en;       // Doze enable.
      logic [2:0]  postscale;      // Fast RC postscaler code.
      logic [5:0]  trim;           // Fast RC trim code.
      logic [3:0]  settle;         // New-clock cycle counter.
      sw_state_e   state;          // Switch sequencer.
      logic [15:0] rdata;          // Registered read data.
   } state_s;

   state_s st_r;                   // Registered state.
   state_s st_nxt;                 // Next state.

   ////////////////////////////////////////////////////////////////////////
   // Decoded helpers.
   logic        sw_allowed;        // Configuration permits switching.
   logic        mon_en;            // Fail-safe monitor enabled.
   logic        rdy_s;             // Synchronised start-up ready.
   logic        pll_s;             // Synchronised lock.
   logic        tick_edge;         // New-clock rising edge seen.
   logic        fail_s;            // Synchronised failure.
   logic        new_pll;           // Target uses the PLL.
   logic        cur_pll;           // Current source uses the PLL.
   logic [15:0] ctrl_word;         // Readable control register.
   logic        wr_ctrl;           // Write to the control register.
   logic        wr_hi;             // High byte selected.
   logic        wr_lo;             // Low byte selected.
   logic [7:0]  wd_hi;             // High byte of write data.
   logic [7:0]  wd_lo;             // Low byte of write data.

   always_comb begin
      sw_allowed = (switch_monitor_config == 2'h0);
      mon_en     = (switch_monitor_config == 2'h0);
      rdy_s      = st_r.sync_rdy[2] & st_r.sync_rdy[1];
      pll_s      = st_r.sync_pll[2] & st_r.sync_pll[1];
      fail_s     = st_r.sync_fail[2] & st_r.sync_fail[1];
      // A rise counts once stages two and three agree high from low.
      tick_edge  = st_r.sync_tick[1] & st_r.sync_tick[2] & ~st_r.tick_lvl;
      new_pll    = (st_r.new_src == SRC_FRC_PLL) ||
                   (st_r.new_src == SRC_PRI_PLL);
      cur_pll    = (st_r.cur_src == SRC_FRC_PLL) ||
                   (st_r.cur_src == SRC_PRI_PLL);
      wr_ctrl    = reg_wr && (reg_addr == ADDR_OSC_CONTROL);
      wr_hi      = reg_wdata[BYTE_SEL_HI];
      wr_lo      = reg_wdata[BYTE_SEL_LO];
      wd_hi      = reg_wdata[15:8];
      wd_lo      = reg_wdata[7:0];
      ctrl_word  = {1'b0, st_r.cur_src, 1'b0, st_r.new_src,
                    st_r.sel_lock, st_r.io_lock, st_r.pll_lock, 1'b0,
                    st_r.fail, st_r.pri_sleep, st_r.sec_en, st_r.sw_req};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for registers, unlock tracking and the sequencer.
   always_comb begin
      st_nxt = st_r;
      // Three-stage synchronisers; the first stage feeds only the second.
      st_nxt.sync_rdy  = {st_r.sync_rdy[1:0],  osc_ready_async};
      st_nxt.sync_pll  = {st_r.sync_pll[1:0],  pll_locked_async};
      st_nxt.sync_tick = {st_r.sync_tick[1:0], new_clk_tick_async};
      st_nxt.sync_fail = {st_r.sync_fail[1:0], clock_fail_async};
      // Agreed new-clock level; a disagreement keeps the old one.
      if (st_r.sync_tick[1] == st_r.sync_tick[2])
         st_nxt.tick_lvl = st_r.sync_tick[2];

      // Straps are caught by a clocked step after reset release.
      if (!st_r.boot_done) begin
         st_nxt.boot_done = 1'b1;
         st_nxt.cur_src   = initial_source_config;
         st_nxt.new_src   = initial_source_config;
      end

      // Unlock keys: any other control write breaks the sequence.
      if (wr_ctrl) begin
         st_nxt.hi_key = 2'h0;
         st_nxt.lo_key = 2'h0;
         if (wr_hi && !wr_lo) begin
            if (wd_hi == KEY_HI_1) st_nxt.hi_key = 2'h1;
            else if (wd_hi == KEY_HI_2 && st_r.hi_key == 2'h1)
               st_nxt.hi_key = 2'h2;
         end
         if (wr_lo && !wr_hi) begin
            if (wd_lo == KEY_LO_1) st_nxt.lo_key = 2'h1;
            else if (wd_lo == KEY_LO_2 && st_r.lo_key == 2'h1)
               st_nxt.lo_key = 2'h2;
         end
         // Unlocked high byte write: only the new source is writable.
         if (wr_hi && st_r.hi_key == 2'h2) begin
            if (!(mon_en && st_r.sel_lock) &&
                st_r.state == ST_IDLE)
               st_nxt.new_src = wd_hi[2:0];
         end
         // Unlocked low byte write.
         if (wr_lo && st_r.lo_key == 2'h2) begin
            if (wd_lo[POS_SEL_LOCK])
               st_nxt.sel_lock = 1'b1;
            if (!(one_way_io_lock && st_r.io_lock))
               st_nxt.io_lock = wd_lo[POS_IO_LOCK];
            if (!wd_lo[POS_FAIL])
               st_nxt.fail = 1'b0;
            st_nxt.pri_sleep = wd_lo[POS_PRI_SLEEP];
            st_nxt.sec_en    = wd_lo[POS_SEC_EN];
            if (wd_lo[POS_SWITCH] && sw_allowed &&
                !(mon_en && st_r.sel_lock))
               st_nxt.sw_req = 1'b1;
         end
      end

      // Failure events win over a software clear in the same cycle.
      if (fail_s && mon_en)
         st_nxt.fail = 1'b1;

      // In idle, lock flag tracks the PLL only while a PLL source runs.
      if (cur_pll && st_r.state == ST_IDLE)
         st_nxt.pll_lock = pll_s;
      else if (!cur_pll && st_r.state == ST_IDLE)
         st_nxt.pll_lock = 1'b0;

      // Divider and trim registers.
      if (reg_wr && reg_addr == ADDR_CLK_DIVIDER) begin
         st_nxt.recover_on_interrupt       = reg_wdata[POS_ROI];
         st_nxt.ratio     = reg_wdata[POS_RATIO +: 3];
         st_nxt.ratio_en  = reg_wdata[POS_RATIO_EN];
         st_nxt.postscale = reg_wdata[POS_POSTSCALE +: 3];
      end
      if (reg_wr && reg_addr == ADDR_FRC_TUNE)
         st_nxt.trim = reg_wdata[5:0];
      // The interrupt wins over a same-cycle write of the enable.
      if (interrupt_event && st_r.recover_on_interrupt)
         st_nxt.ratio_en = 1'b0;

      // Switch sequencer.
      case (st_r.state)
         ST_IDLE: begin
            if (st_r.sw_req) begin
               if (st_r.new_src == st_r.cur_src)
                  st_nxt.sw_req = 1'b0;
               else
                  st_nxt.state = ST_START;
            end
         end
         ST_START: begin
            st_nxt.pll_lock = 1'b0;
            st_nxt.fail     = fail_s & mon_en;
            st_nxt.state    = ST_WAIT;
         end
         ST_WAIT: begin
            // Wait on start-up timer and, for PLL targets, lock.
            if (new_pll) st_nxt.pll_lock = pll_s;
            if (rdy_s && (!new_pll || pll_s)) begin
               st_nxt.settle = 4'h0;
               st_nxt.state  = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (new_pll) st_nxt.pll_lock = pll_s;
            // Each rising edge of the new clock counts once.
            if (tick_edge) begin
               st_nxt.settle = st_r.settle + 4'h1;
               if (st_r.settle + 4'h1 == SETTLE_CYCLES)
                  st_nxt.state = ST_SWAP;
            end
         end
         ST_SWAP: begin
            st_nxt.cur_src = st_r.new_src;
            st_nxt.sw_req  = 1'b0;
            st_nxt.state   = ST_IDLE;
         end
         default: st_nxt.state = ST_IDLE;
      endcase
      if (!sw_allowed) begin
         st_nxt.sw_req = 1'b0;
         st_nxt.state  = ST_IDLE;
         if (st_r.boot_done)
            st_nxt.cur_src = initial_source_config;
      end

      // Read data stands in the cycle after the strobe only.
      st_nxt.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_OSC_CONTROL: st_nxt.rdata = ctrl_word;
            ADDR_CLK_DIVIDER: st_nxt.rdata = {st_r.recover_on_interrupt, st_r.ratio,
                                 st_r.ratio_en, st_r.postscale, 8'h00};
            ADDR_FRC_TUNE:    st_nxt.rdata = {10'h000, st_r.trim};
            default:          st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register with constant reset values.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r           <= '0;
         st_r.postscale <= RST_POSTSCALE;
         st_r.ratio     <= RST_RATIO;
         st_r.trim      <= RST_TRIM;
         st_r.cur_src   <= SRC_FRC;
         st_r.new_src   <= SRC_FRC;
         st_r.state     <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs toward the clock tree and oscillators.
   always_comb begin
      reg_rdata        = st_r.rdata;
      system_source    = st_r.cur_src;
      primary_submode  = primary_submode_config;
      pll_select       = cur_pll;
      io_lock_out      = st_r.io_lock;
      fast_rc_trim_out = st_r.trim;
      cpu_ratio_log2   = st_r.ratio_en ? st_r.ratio : 3'h0;
      // Code 111 divides by 256, others by two to the code.
      fast_rc_div_log2 = (st_r.postscale == 3'h7) ? 4'h8 :
                         {1'b0, st_r.postscale};
      // Only the running source and the target are on; the old one
      // drops at the swap except for the kept low-power and secondary.
      osc_enable = 8'h00;
      osc_enable[st_r.cur_src] = 1'b1;
      if (st_r.state != ST_IDLE)
         osc_enable[st_r.new_src] = 1'b1;
      if (watchdog_enable || mon_en)
         osc_enable[SRC_LOW_POWER_RC_OSC] = 1'b1;
      if (st_r.sec_en)
         osc_enable[SRC_SEC] = 1'b1;
      if (sleep_mode && !st_r.pri_sleep) begin
         osc_enable[SRC_PRI]     = 1'b0;
         osc_enable[SRC_PRI_PLL] = 1'b0;
      end
   end

endmodule : osc_switch_ctrl

// >>> sim/osc_switch_properties.sv
// Checker for the oscillator switch control block, bound to its top module.
// Assumes it sees only the block's ports, in the register clock domain.
`timescale 1ns/1ns
module osc_switch_properties
   import osc_switch_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [1:0]  reg_addr,
   input wire logic [17:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic [1:0]  switch_monitor_config,
   input wire logic [2:0]  initial_source_config,
   input wire logic [1:0]  primary_submode_config,
   input wire logic        one_way_io_lock,
   input wire logic        interrupt_event,
   input wire logic        sleep_mode,
   input wire logic [2:0]  system_source,
   input wire logic [7:0]  osc_enable,
   input wire logic [1:0]  primary_submode,
   input wire logic [2:0]  cpu_ratio_log2,
   input wire logic [3:0]  fast_rc_div_log2,
   input wire logic signed [5:0] fast_rc_trim_out,
   input wire logic        io_lock_out,
   input wire logic        pll_select
);
   // One clock domain, so clocking and reset are stated once.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////
   // The past-reset guards skip the edge that loads the initial source.
   a_disabled_source: assert property ($past(rstn) && switch_monitor_config[1]
      |-> system_source == initial_source_config)
      else $error("source differs from configuration while locked out");
   a_switch_gated: assert property ($past(rstn) && switch_monitor_config[1]
      |=> $stable(system_source))
      else $error("source changed with switching disabled");
   a_pll_select: assert property ($past(rstn) |-> pll_select ==
      (system_source == SRC_FRC_PLL || system_source == SRC_PRI_PLL))
      else $error("pll select does not match source code");
   a_submode_fixed: assert property (
      primary_submode == primary_submode_config)
      else $error("primary submode differs from configuration");
   a_trim_write: assert property (reg_wr && reg_addr == ADDR_FRC_TUNE
      |=> fast_rc_trim_out == $past(reg_wdata[5:0]))
      else $error("trim output does not follow written code");
   a_post_write: assert property (reg_wr && reg_addr == ADDR_CLK_DIVIDER
      |=> fast_rc_div_log2 == (($past(reg_wdata[10:8]) == 3'h7) ? 4'h8 :
      {1'b0, $past(reg_wdata[10:8])}))
      else $error("postscaler shift wrong after write");
   a_ratio_write: assert property (reg_wr && reg_addr == ADDR_CLK_DIVIDER
      && !interrupt_event |=> cpu_ratio_log2 == ($past(reg_wdata[11]) ?
      $past(reg_wdata[14:12]) : 3'h0))
      else $error("doze shift wrong after write");
   a_ratio_hold: assert property ($past(rstn) && !interrupt_event &&
      !(reg_wr && reg_addr == ADDR_CLK_DIVIDER) |=>
      $stable(cpu_ratio_log2))
      else $error("doze shift changed without cause");
   a_io_oneway: assert property (one_way_io_lock && io_lock_out
      |=> io_lock_out)
      else $error("one-way io lock was cleared");
   a_source_on: assert property ($past(rstn) && !sleep_mode
      |-> osc_enable[system_source] && (switch_monitor_config != 2'h0
      || osc_enable[SRC_LOW_POWER_RC_OSC]))
      else $error("system source oscillator not enabled");

   // Main scenarios reached by the bench.
   c_swap: cover property ($changed(system_source));
   c_recover: cover property (interrupt_event && cpu_ratio_log2 != 3'h0);
   c_io_lock: cover property ($rose(io_lock_out));
   c_trim: cover property (reg_wr && reg_addr == ADDR_FRC_TUNE);
endmodule : osc_switch_properties

bind osc_switch_ctrl osc_switch_properties u_props (.*);

// >>> sim/test_oscillator_switch_control.sv
// Self-checking bench for the oscillator switch control block.
// Assumes the plain register port and a bench-made new-source clock.
`timescale 1ns/1ns
module test_oscillator_switch_control;
   import osc_switch_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [1:0]  reg_addr = 2'h0;
   logic [17:0] reg_wdata = 18'h00000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [1:0]  cfg = 2'h0;        // Switch and monitor configuration.
   logic        ready = 1'b0;      // Start-up timer done.
   logic        locked = 1'b0;     // PLL lock detector.
   logic        tick = 1'b0;       // New source clock, period 4 cycles.
   logic [1:0]  tick_div = 2'h0;
   logic        fail = 1'b0;       // Monitor failure level.
   logic        irq = 1'b0;        // Core interrupt.
   logic [2:0]  system_source;
   logic [7:0]  osc_enable;
   logic [2:0]  cpu_ratio_log2;
   logic [3:0]  fast_rc_div_log2;
   logic signed [5:0] fast_rc_trim_out;
   logic        io_lock_out;
   logic        pll_select;
   logic [15:0] q;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;

   osc_switch_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .switch_monitor_config(cfg),
      .initial_source_config(SRC_FRC_DIV), .primary_submode_config(2'h1),
      .one_way_io_lock(1'b1), .watchdog_enable(1'b0),
      .osc_ready_async(ready), .pll_locked_async(locked),
      .new_clk_tick_async(tick), .clock_fail_async(fail),
      .interrupt_event(irq), .sleep_mode(1'b0),
      .system_source(system_source), .osc_enable(osc_enable),
      .primary_submode(), .cpu_ratio_log2(cpu_ratio_log2),
      .fast_rc_div_log2(fast_rc_div_log2),
      .fast_rc_trim_out(fast_rc_trim_out), .io_lock_out(io_lock_out),
      .pll_select(pll_select));

   ////////////////////////////////////////////////////////////////////////
   // Clock, new-source clock and hang guard.
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      tick_div <= tick_div + 2'h1;
      tick     <= tick_div[1];
      cycles   <= cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus tasks change signals just after an edge; a write leaves its
   // strobe up so unlock keys reach the block in consecutive cycles.
   task automatic wr(input logic [1:0] a, input logic [17:0] d);
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      #1;
   endtask : wr
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : idle
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      reg_wr   <= 1'b0;
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_rd(input logic [1:0] a, input logic [15:0] exp);
      rd(a, q);
      chk_val(q, exp);
   endtask : chk_rd
   // Keyed byte writes: high byte carries the new source in bits 10:8.
   task automatic unlock_hi(input logic [7:0] v);
      wr(ADDR_OSC_CONTROL, {2'b10, KEY_HI_1, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b10, KEY_HI_2, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b10, v, 8'h00});
   endtask : unlock_hi
   task automatic unlock_lo(input logic [7:0] v);
      wr(ADDR_OSC_CONTROL, {2'b01, 8'h00, KEY_LO_1});
      wr(ADDR_OSC_CONTROL, {2'b01, 8'h00, KEY_LO_2});
      wr(ADDR_OSC_CONTROL, {2'b01, 8'h00, v});
      idle(1);
   endtask : unlock_lo
   task automatic start_switch(input logic [2:0] s, input logic [7:0] keep);
      unlock_hi({5'h00, s});
      unlock_lo(keep | 8'h01);
   endtask : start_switch
   task automatic wait_done();
      q = 16'h0001;
      for (int i = 0; i < 80 && q[0] !== 1'b0; i++) rd(ADDR_OSC_CONTROL, q);
      chk_val({15'h0000, q[0]}, 16'h0000);
   endtask : wait_done
   task automatic reset(input logic [1:0] c);
      rstn <= 1'b0;
      cfg  <= c;
      idle(2);
      rstn <= 1'b1;
      idle(2);
   endtask : reset
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // Test sequence.
   initial begin
      reset(2'h0);
      chk_rd(ADDR_OSC_CONTROL, 16'h7700);
      chk_rd(ADDR_CLK_DIVIDER, 16'h0100);
      chk_rd(ADDR_FRC_TUNE, 16'h0000);
      chk_rd(2'h3, 16'h0000);
      // Writes without keys or with keys swapped are dropped.
      wr(ADDR_OSC_CONTROL, {2'b10, 8'h02, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b10, KEY_HI_2, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b10, KEY_HI_1, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b10, 8'h02, 8'h00});
      wr(ADDR_OSC_CONTROL, {2'b01, 8'h00, 8'h02});
      idle(1);
      chk_rd(ADDR_OSC_CONTROL, 16'h7700);
      start_switch(SRC_FRC_DIV, 8'h00);
      idle(3);
      chk_rd(ADDR_OSC_CONTROL, 16'h7700);
      $display("Test reset and refusal done");
      // Failure flag, then a switch that waits for start-up and settling.
      fail <= 1'b1;
      idle(6);
      chk_rd(ADDR_OSC_CONTROL, 16'h7708);
      fail <= 1'b0;
      start_switch(SRC_FRC, 8'h08);
      idle(20);
      chk_rd(ADDR_OSC_CONTROL, 16'h7001);
      ready <= 1'b1;
      idle(30);
      chk_val({13'h0000, system_source}, {13'h0000, SRC_FRC_DIV});
      wait_done();
      chk_rd(ADDR_OSC_CONTROL, 16'h0000);
      chk_val({13'h0000, system_source}, {13'h0000, SRC_FRC});
      // PLL target waits for lock; lock flag clears again on next switch.
      start_switch(SRC_FRC_PLL, 8'h00);
      idle(50);
      chk_rd(ADDR_OSC_CONTROL, 16'h0101);
      locked <= 1'b1;
      wait_done();
      chk_rd(ADDR_OSC_CONTROL, 16'h1120);
      chk_val({15'h0000, pll_select}, 16'h0001);
      start_switch(SRC_FRC, 8'h00);
      idle(1);
      chk_rd(ADDR_OSC_CONTROL, 16'h1001);
      wait_done();
      chk_rd(ADDR_OSC_CONTROL, 16'h0000);
      locked <= 1'b0;
      $display("Test clock switching done");
      // Every doze and postscaler code, then recovery on interrupt.
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_CLK_DIVIDER, 18'((c << 12) | 16'h0800 | (c << 8)));
         idle(1);
         chk_val(16'(cpu_ratio_log2), 16'(c));
         chk_val(16'(fast_rc_div_log2), (c == 7) ? 16'h0008 : 16'(c));
      end
      for (int r = 0; r < 2; r++) begin
         wr(ADDR_CLK_DIVIDER, r ? 18'h03B00 : 18'h0BB00);
         irq <= 1'b1;
         idle(1);
         irq <= 1'b0;
         idle(1);
         chk_rd(ADDR_CLK_DIVIDER, r ? 16'h3B00 : 16'hB300);
      end
      // Trim codes at both ends, unused bits read as zero.
      foreach (q[i]) if (i < 3) begin
         wr(ADDR_FRC_TUNE, (i == 0) ? 18'h0FFFF :
            (i == 1) ? 18'h00020 : 18'h0001F);
         idle(1);
         chk_rd(ADDR_FRC_TUNE, (i == 0) ? 16'h003F :
            (i == 1) ? 16'h0020 : 16'h001F);
      end
      $display("Test divider and trim done");
      // Secondary force-on, one-way io lock, then the selection lock.
      unlock_lo(8'h42);
      chk_val({15'h0000, osc_enable[SRC_SEC]}, 16'h0001);
      unlock_lo(8'h00);
      chk_rd(ADDR_OSC_CONTROL, 16'h0040);
      unlock_lo(8'hC0);
      start_switch(SRC_LOW_POWER_RC_OSC, 8'hC0);
      idle(60);
      chk_val({13'h0000, system_source}, {13'h0000, SRC_FRC});
      // Switching disabled by configuration.
      reset(2'h2);
      start_switch(SRC_FRC, 8'h00);
      idle(60);
      rd(ADDR_OSC_CONTROL, q);
      chk_val(q & 16'hF001, 16'h7000);
      chk_val({13'h0000, system_source}, {13'h0000, SRC_FRC_DIV});
      $display("Test locks and disabled switching done");
      give_verdict();
   end
endmodule : test_oscillator_switch_control
